// File: verilog/uoc_link.sv
`timescale 1ns/1ps
`include "uoc_regs.svh"

// Notes on behaviour
// - otg control: read 0a-0c, write/set/clear
// - bit 7 picks comparator or fault pin
// - bit 6 drives switch pin low
// - bit 5 asks internal 5 V supply
// - bit 4 charges bus power
// - charge only after discharge and 2 ms low
// - discharge until session end rises, then clear
// - bit 2 minus line pull-down, reset 1
// - bit 1 plus line pull-down, reset 1
// - never write one to bit 0
// - rising enable gates events and event bytes
// - rising enable resets to 1f
// - rising enable set 0e, clear 0f
// - rising enable read 0d-0f, write 0d
// - enable bits: end, ok, power, detach
module uoc_link
    import uoc_pkg::*;
#(
    parameter int unsigned SE0_HOLD_CYC = `UOC_SE0_HOLD_CYC
)
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // transceiver side
    uoc_if.link ulpi
);
    uoc_link_state_e state_q, state_d;
    logic pready_q, pready_d;
    logic [31:0] prdata_q, prdata_d;
    logic [2:0] intStat_q, intStat_d, intMask_q, intMask_d, intSet;
    logic lineSe0_q, lineSe0_d;
    logic [15:0] se0Cnt_q, se0Cnt_d;
    logic sessEnd_q, sessEnd_d;
    logic stopPending_q, stopPending_d;
    logic [5:0] addr_q, addr_d;
    logic wr_q, wr_d;
    logic [7:0] wdata_q, wdata_d, rdata_q, rdata_d, lastRx_q, lastRx_d;
    logic irq_q;
    logic apbWr, apbRd, chargeOk, chargeAsk, cmdWrites, cmdHitsOtg;
    logic [5:0] cmdAddr, cmdTarget;
    logic [7:0] cmdData;
    logic [1:0] cmdOp;

    // writes land at the edge that samples pready high; reads are captured a cycle before it
    assign apbWr = psel && penable && pwrite && pready_q;
    assign apbRd = psel && penable && !pwrite && !pready_q;
    // command word: data, base address, operation
    assign cmdAddr = pwdata[13:8];
    assign cmdOp = pwdata[17:16];
    assign cmdWrites = (cmdOp != 2'(UOC_OP_READ));
    // set and clear land on base+1 and base+2
    assign cmdTarget = (cmdOp == 2'(UOC_OP_SET)) ? cmdAddr + 6'h01 :
        (cmdOp == 2'(UOC_OP_CLEAR)) ? cmdAddr + 6'h02 : cmdAddr;
    // judged on the final address, so no mix of base and operation slips past the guards
    assign cmdHitsOtg = cmdWrites && (cmdTarget == `UOC_OTG_WR || cmdTarget == `UOC_OTG_SET);
    // reserved bit 0 is forced low on every otg control write or set
    assign cmdData = cmdHitsOtg ? {pwdata[7:1], 1'b0} : pwdata[7:0];
    // charging needs a discharged bus and the lines low for the whole hold time
    assign chargeAsk = cmdHitsOtg && pwdata[`UOC_CHARGE];
    assign chargeOk = sessEnd_q && (se0Cnt_q >= 16'(SE0_HOLD_CYC));

    always_comb begin
        state_d = state_q;
        pready_d = psel && penable && !pready_q;
        prdata_d = prdata_q;
        intSet = 3'h0;
        intMask_d = intMask_q;
        lineSe0_d = lineSe0_q;
        // saturates at the hold time so it never wraps while the lines stay low
        se0Cnt_d = !lineSe0_q ? 16'h0000 : (se0Cnt_q >= 16'(SE0_HOLD_CYC) ? se0Cnt_q : se0Cnt_q + 16'h0001);
        sessEnd_d = sessEnd_q;
        stopPending_d = stopPending_q;
        addr_d = addr_q;
        wr_d = wr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        lastRx_d = lastRx_q;
        // every event byte is kept; its session-end bit stands for a discharged bus
        if (ulpi.rxValid) begin
            lastRx_d = ulpi.rxData;
            intSet[`UOC_INT_RXCMD] = 1'b1;
            sessEnd_d = ulpi.rxData[`UOC_SRC_SESSION_END_FLAG];
            if (ulpi.rxData[`UOC_SRC_SESSION_END_FLAG] && !sessEnd_q) begin
                stopPending_d = 1'b1;
            end
        end
        // a command written while busy is dropped, so software polls the busy flag first
        unique case (state_q)
            UOC_LINK_IDLE: begin
                if (apbWr && paddr == `UOC_APB_CMD) begin
                    if (chargeAsk && !chargeOk) begin
                        intSet[`UOC_INT_REFUSED] = 1'b1;
                    end else begin
                        state_d = UOC_LINK_BUSY;
                        wr_d = cmdWrites;
                        addr_d = cmdTarget;
                        wdata_d = cmdData;
                    end
                end else if (stopPending_q) begin
                    // the link ends the discharge itself, software need not watch event bytes
                    stopPending_d = ulpi.rxValid && ulpi.rxData[`UOC_SRC_SESSION_END_FLAG] && !sessEnd_q;
                    state_d = UOC_LINK_BUSY;
                    wr_d = 1'b1;
                    addr_d = `UOC_OTG_CLR;
                    wdata_d = 8'h01 << `UOC_DISCHARGE;
                end
            end
            UOC_LINK_BUSY: begin
                if (ulpi.regAck) begin
                    state_d = UOC_LINK_IDLE;
                    // read data stands from the acknowledge cycle until the next access, and is caught in the acknowledge cycle
                    rdata_d = ulpi.regRdata;
                    intSet[`UOC_INT_DONE] = 1'b1;
                end
            end
        endcase
        // set wins over a simultaneous write-one-to-clear
        intStat_d = intStat_q;
        if (apbWr && paddr == `UOC_APB_INT_STAT) begin
            intStat_d = intStat_q & ~pwdata[2:0];
        end
        intStat_d = intStat_d | intSet;
        // mask has the same layout as the status
        if (apbWr && paddr == `UOC_APB_INT_MASK) begin
            intMask_d = pwdata[2:0];
        end
        // software reports here whether both data lines sit in single-ended zero
        if (apbWr && paddr == `UOC_APB_CTRL) begin
            lineSe0_d = pwdata[0];
        end
        if (apbRd) begin
            // status word: event byte, read data, then stop, session end, charge ok, busy
            unique case (paddr)
                `UOC_APB_STAT: prdata_d = {8'h00, lastRx_q, rdata_q, 4'h0, stopPending_q, sessEnd_q, chargeOk,
                    state_q == UOC_LINK_BUSY};
                `UOC_APB_INT_STAT: prdata_d = {29'h0, intStat_q};
                `UOC_APB_INT_MASK: prdata_d = {29'h0, intMask_q};
                `UOC_APB_CTRL: prdata_d = {31'h0, lineSe0_q};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= UOC_LINK_IDLE;
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            intStat_q <= 3'h0;
            intMask_q <= 3'h0;
            lineSe0_q <= 1'b0;
            se0Cnt_q <= 16'h0000;
            sessEnd_q <= 1'b0;
            stopPending_q <= 1'b0;
            addr_q <= 6'h00;
            wr_q <= 1'b0;
            wdata_q <= 8'h00;
            rdata_q <= 8'h00;
            lastRx_q <= 8'h00;
            irq_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            pready_q <= pready_d;
            prdata_q <= prdata_d;
            intStat_q <= intStat_d;
            intMask_q <= intMask_d;
            lineSe0_q <= lineSe0_d;
            se0Cnt_q <= se0Cnt_d;
            sessEnd_q <= sessEnd_d;
            stopPending_q <= stopPending_d;
            addr_q <= addr_d;
            wr_q <= wr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            lastRx_q <= lastRx_d;
            // next-state values, so irq rises in step with the status bit
            irq_q <= |(intStat_d & intMask_d);
        end
    end

    // the request stands for the whole busy state and drops the cycle after the acknowledge
    assign ulpi.regReq = (state_q == UOC_LINK_BUSY);
    assign ulpi.regAddr = addr_q;
    assign ulpi.regWrite = wr_q;
    assign ulpi.regWdata = wdata_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    // every access completes; there is no error response
    assign pslverr = 1'b0;
    assign irq = irq_q;
endmodule

// File: verilog/uoc_regs.svh
`ifndef UOC_REGS_SVH
`define UOC_REGS_SVH

// transceiver register addresses (read at all three, write/set/clear one each)
`define UOC_OTG_WR 6'h0a
`define UOC_OTG_SET 6'h0b
`define UOC_OTG_CLR 6'h0c
`define UOC_RISE_WR 6'h0d
`define UOC_RISE_SET 6'h0e
`define UOC_RISE_CLR 6'h0f
`define UOC_OTG_RESET 8'h06
`define UOC_RISE_RESET 8'h1f

// otg_control fields
`define UOC_EXT_VALID_SEL 7
`define UOC_EXT_SWITCH_ON 6
`define UOC_INT_SUPPLY_ON 5
`define UOC_CHARGE 4
`define UOC_DISCHARGE 3
`define UOC_MINUS_PD 2
`define UOC_PLUS_PD 1
`define UOC_RESERVED0 0

// event source / rising enable fields
`define UOC_SRC_SESSION_END_FLAG 3
`define UOC_SRC_SESS_OK 2
`define UOC_SRC_BUS_OK 1
`define UOC_SRC_HOST_DET 0

// link controller apb registers
`define UOC_APB_CMD 8'h00
`define UOC_APB_STAT 8'h04
`define UOC_APB_INT_STAT 8'h08
`define UOC_APB_INT_MASK 8'h0c
`define UOC_APB_CTRL 8'h10
`define UOC_INT_DONE 0
`define UOC_INT_RXCMD 1
`define UOC_INT_REFUSED 2

// both data lines held low before a charge pulse
`define UOC_SE0_HOLD_US 2000
`define UOC_CLK_KHZ 20000
`define UOC_SE0_HOLD_CYC (`UOC_SE0_HOLD_US * `UOC_CLK_KHZ / 1000)

`endif

// File: verilog/uoc_pkg.sv
package uoc_pkg;
    typedef enum logic [1:0] {
        UOC_OP_READ,
        UOC_OP_WRITE,
        UOC_OP_SET,
        UOC_OP_CLEAR
    } uoc_op_e;

    typedef enum logic {
        UOC_LINK_IDLE,
        UOC_LINK_BUSY
    } uoc_link_state_e;

    typedef logic [7:0] uoc_byte_t;
endpackage

// File: verilog/uoc_if.sv
`timescale 1ns/1ps
interface uoc_if;
    // register access, link to transceiver
    logic regReq;
    logic [5:0] regAddr;
    logic regWrite;
    logic [7:0] regWdata;
    // answers and event bytes, transceiver to link
    logic regAck;
    logic [7:0] regRdata;
    logic rxValid;
    logic [7:0] rxData;

    modport dev (input regReq, regAddr, regWrite, regWdata, output regAck, regRdata, rxValid, rxData);
    modport link (output regReq, regAddr, regWrite, regWdata, input regAck, regRdata, rxValid, rxData);
endinterface

// File: verilog/uoc_device.sv
`timescale 1ns/1ps
`include "uoc_regs.svh"

module uoc_device
    import uoc_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // register access and event bytes
    uoc_if.dev ulpi,
    // analog status sources, asynchronous
    input wire logic [3:0] sourceLevels,
    input wire logic faultIn,
    // analog controls
    output logic extValidSelect,
    output logic powerSwitchOut_n,
    output logic powerSwitchOe_n,
    output logic internalSupplyOn,
    output logic busPowerCharge,
    output logic busPowerDischarge,
    output logic minusPulldown,
    output logic plusPulldown,
    output logic busPowerOk,
    output logic riseIrq
);
    logic [7:0] otgCtrl_q, otgCtrl_d;
    logic [7:0] riseEn_q, riseEn_d;
    logic [4:0] sync1_q, sync2_q;
    logic [3:0] srcPrev_q, srcPrev_d, srcNow, rise;
    logic ack_q, ack_d;
    logic [7:0] rdata_q, rdata_d;
    logic rxValid_q, rxValid_d;
    logic [7:0] rxData_q, rxData_d;
    logic irq_q, irq_d;
    logic [7:0] ctlOut_q;

    function automatic logic [7:0] apply_op(input logic [7:0] cur, input logic [1:0] sel, input logic [7:0] wd);
        logic [7:0] res;
        res = cur;
        unique case (sel)
            2'h0: res = wd;
            2'h1: res = cur | wd;
            2'h2: res = cur & ~wd;
            default: res = cur;
        endcase
        return res;
    endfunction

    // bus-power valid follows the comparator or the fault pin
    always_comb begin
        srcNow = sync2_q[3:0];
        srcNow[`UOC_SRC_BUS_OK] = otgCtrl_q[`UOC_EXT_VALID_SEL] ? sync2_q[4] : sync2_q[`UOC_SRC_BUS_OK];
        rise = srcNow & ~srcPrev_q & riseEn_q[3:0];
    end

    always_comb begin
        otgCtrl_d = otgCtrl_q;
        riseEn_d = riseEn_q;
        ack_d = 1'b0;
        rdata_d = rdata_q;
        srcPrev_d = srcNow;
        rxValid_d = |rise;
        rxData_d = (|rise) ? {4'h0, srcNow} : rxData_q;
        irq_d = |rise;
        if (ulpi.regReq && !ack_q) begin
            ack_d = 1'b1;
            if (ulpi.regAddr >= `UOC_OTG_WR && ulpi.regAddr <= `UOC_OTG_CLR) begin
                rdata_d = otgCtrl_q;
                if (ulpi.regWrite) begin
                    otgCtrl_d = apply_op(otgCtrl_q, 2'(ulpi.regAddr - `UOC_OTG_WR), ulpi.regWdata);
                end
            end else if (ulpi.regAddr >= `UOC_RISE_WR && ulpi.regAddr <= `UOC_RISE_CLR) begin
                rdata_d = riseEn_q;
                if (ulpi.regWrite) begin
                    riseEn_d = apply_op(riseEn_q, 2'(ulpi.regAddr - `UOC_RISE_WR), ulpi.regWdata);
                end
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            otgCtrl_q <= `UOC_OTG_RESET;
            riseEn_q <= `UOC_RISE_RESET;
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            srcPrev_q <= 4'h0;
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
            rxValid_q <= 1'b0;
            rxData_q <= 8'h00;
            irq_q <= 1'b0;
            ctlOut_q <= `UOC_OTG_RESET;
        end else if (ce) begin
            otgCtrl_q <= otgCtrl_d;
            riseEn_q <= riseEn_d;
            sync1_q <= {faultIn, sourceLevels};
            sync2_q <= sync1_q;
            srcPrev_q <= srcPrev_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            rxValid_q <= rxValid_d;
            rxData_q <= rxData_d;
            irq_q <= irq_d;
            ctlOut_q <= otgCtrl_d;
        end
    end

    assign ulpi.regAck = ack_q;
    assign ulpi.regRdata = rdata_q;
    assign ulpi.rxValid = rxValid_q;
    assign ulpi.rxData = rxData_q;

    // controls mirror the register from their own flop copy
    assign extValidSelect = ctlOut_q[`UOC_EXT_VALID_SEL];
    assign powerSwitchOut_n = 1'b0;
    assign powerSwitchOe_n = ~ctlOut_q[`UOC_EXT_SWITCH_ON];
    assign internalSupplyOn = ctlOut_q[`UOC_INT_SUPPLY_ON];
    assign busPowerCharge = ctlOut_q[`UOC_CHARGE];
    assign busPowerDischarge = ctlOut_q[`UOC_DISCHARGE];
    assign minusPulldown = ctlOut_q[`UOC_MINUS_PD];
    assign plusPulldown = ctlOut_q[`UOC_PLUS_PD];
    assign busPowerOk = srcPrev_q[`UOC_SRC_BUS_OK];
    assign riseIrq = irq_q;
endmodule

// File: dv/uoc_properties.sv
`timescale 1ns/1ps
module uoc_properties (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // link to transceiver
    input wire logic regReq,
    input wire logic [5:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    // transceiver to link
    input wire logic regAck,
    input wire logic [7:0] regRdata,
    input wire logic rxValid,
    input wire logic [7:0] rxData
);
    logic [7:0] otgShadow_q, otgShadow_d, riseShadow_q, riseShadow_d;

    // shadows follow every taken write so reads can be checked at any time
    always_comb begin
        otgShadow_d = otgShadow_q;
        riseShadow_d = riseShadow_q;
        if (regAck && regWrite) begin
            case (regAddr)
                6'h0a: otgShadow_d = regWdata;
                6'h0b: otgShadow_d = otgShadow_q | regWdata;
                6'h0c: otgShadow_d = otgShadow_q & ~regWdata;
                6'h0d: riseShadow_d = regWdata;
                6'h0e: riseShadow_d = riseShadow_q | regWdata;
                6'h0f: riseShadow_d = riseShadow_q & ~regWdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            otgShadow_q <= 8'h06;
            riseShadow_q <= 8'h1f;
        end else begin
            otgShadow_q <= otgShadow_d;
            riseShadow_q <= riseShadow_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_ack_next;
        regReq && !regAck |=> regAck;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not acknowledged next cycle");
    property p_ack_once;
        regAck |=> !regAck;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("acknowledge longer than one cycle");
    property p_ack_cause;
        regAck |-> $past(regReq) && !$past(regAck);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without request");
    property p_req_hold;
        regReq && !regAck |=> $stable(regAddr) && $stable(regWrite) && $stable(regWdata);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request changed before acknowledge");
    property p_otg_read;
        regAck && !regWrite && regAddr inside {[6'h0a:6'h0c]} |-> regRdata == otgShadow_q;
    endproperty
    a_otg_read: assert property (p_otg_read) else $error("otg control read mismatch");
    property p_rise_read;
        regAck && !regWrite && regAddr inside {[6'h0d:6'h0f]} |-> regRdata == riseShadow_q;
    endproperty
    a_rise_read: assert property (p_rise_read) else $error("rising enable read mismatch");
    property p_bit0;
        regReq && regWrite && regAddr inside {6'h0a, 6'h0b} |-> !regWdata[0];
    endproperty
    a_bit0: assert property (p_bit0) else $error("reserved otg bit written as one");
    property p_rx_gate;
        rxValid |-> (rxData[3:0] & riseShadow_q[3:0]) != 4'h0 && rxData[7:4] == 4'h0;
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("event byte without enabled source");
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
`include "uoc_regs.svh"
module tb
    import uoc_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r, stat;
    logic pready, pslverr, irq, riseIrq, extValidSelect, powerSwitchOut_n, powerSwitchOe_n, internalSupplyOn;
    logic busPowerCharge, busPowerDischarge, minusPulldown, plusPulldown, busPowerOk;
    logic [3:0] src = 4'h0;
    logic faultIn = 1'b1;
    int num_errors = 0;
    int num_checks = 0;
    int riseCount = 0;
    int n;
    int riseBase;

    uoc_if bus ();
    uoc_link #(.SE0_HOLD_CYC(20)) uoc_link_i (.clk(clk), .arst_n(arst_n), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .ulpi(bus.link));
    uoc_device uoc_device_i (.clk(clk), .arst_n(arst_n), .ce(1'b1), .ulpi(bus.dev), .sourceLevels(src),
        .faultIn(faultIn), .extValidSelect(extValidSelect), .powerSwitchOut_n(powerSwitchOut_n),
        .powerSwitchOe_n(powerSwitchOe_n), .internalSupplyOn(internalSupplyOn),
        .busPowerCharge(busPowerCharge), .busPowerDischarge(busPowerDischarge),
        .minusPulldown(minusPulldown), .plusPulldown(plusPulldown), .busPowerOk(busPowerOk), .riseIrq(riseIrq));
    uoc_properties uoc_properties_i (.clk(clk), .arst_n(arst_n), .regReq(bus.regReq), .regAddr(bus.regAddr),
        .regWrite(bus.regWrite), .regWdata(bus.regWdata), .regAck(bus.regAck), .regRdata(bus.regRdata),
        .rxValid(bus.rxValid), .rxData(bus.rxData));

    always #25 clk = ~clk;

    always @(posedge clk) begin
        if (riseIrq === 1'b1) begin
            riseCount++;
        end
    end

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // a fresh edge first, so a release never meets the next setup in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        chk("slave error", {31'h0, pslverr}, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmd(input uoc_op_e op, input logic [5:0] base, input logic [7:0] d);
        apb(1'b1, `UOC_APB_CMD, {14'h0, op, 2'h0, base, d});
        do begin
            apb(1'b0, `UOC_APB_STAT, 32'h0);
            stat = r;
        end while (stat[0] !== 1'b0);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string name);
        cmd(UOC_OP_READ, a, 8'h00);
        chk(name, {24'h0, stat[15:8]}, {24'h0, exp});
    endtask

    // outputs are synchronised inside, so give them a few cycles to land
    task automatic settle;
        repeat (5) @(negedge clk);
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run;
    end

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rd(6'h0a + 6'(i), 8'h06, "otg reset");
            rd(6'h0d + 6'(i), 8'h1f, "rise reset");
        end
        settle;
        chk("reset outputs", {minusPulldown, plusPulldown, powerSwitchOe_n, busPowerCharge}, 4'b1110);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", r, 32'h0);
        apb(1'b1, `UOC_APB_INT_STAT, 32'h7);
        cmd(UOC_OP_SET, 6'h0a, 8'h10);
        apb(1'b0, `UOC_APB_INT_STAT, 32'h0);
        chk("refused flag", r[2], 1'b1);
        chk("no charge", busPowerCharge, 1'b0);
        cmd(UOC_OP_WRITE, 6'h0a, 8'hc6);
        settle;
        chk("external select", {extValidSelect, powerSwitchOe_n, powerSwitchOut_n, busPowerOk}, 4'b1001);
        cmd(UOC_OP_SET, 6'h0a, 8'h21);
        settle;
        chk("supply on", internalSupplyOn, 1'b1);
        cmd(UOC_OP_CLEAR, 6'h0a, 8'hc6);
        settle;
        chk("comparator select", {extValidSelect, powerSwitchOe_n, internalSupplyOn, busPowerOk, minusPulldown,
            plusPulldown}, 6'b011000);
        rd(6'h0a, 8'h20, "otg after clear");
        apb(1'b1, `UOC_APB_INT_STAT, 32'h7);
        apb(1'b1, `UOC_APB_INT_MASK, 32'h2);
        cmd(UOC_OP_SET, 6'h0a, 8'h08);
        settle;
        chk("discharge on", busPowerDischarge, 1'b1);
        @(posedge clk);
        src <= 4'h8;
        riseBase = riseCount;
        n = 0;
        while (busPowerDischarge !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("discharge stopped", busPowerDischarge, 1'b0);
        chk("event irq", irq, 1'b1);
        chk("end rise", riseCount, riseBase + 1);
        rd(6'h0a, 8'h20, "otg after stop");
        apb(1'b1, `UOC_APB_INT_STAT, 32'h2);
        settle;
        chk("irq cleared", irq, 1'b0);
        apb(1'b1, `UOC_APB_CTRL, 32'h1);
        repeat (25) @(posedge clk);
        cmd(UOC_OP_SET, 6'h0a, 8'h10);
        settle;
        chk("charge on", busPowerCharge, 1'b1);
        cmd(UOC_OP_WRITE, 6'h0d, 8'h0f);
        cmd(UOC_OP_SET, 6'h0d, 8'h10);
        cmd(UOC_OP_CLEAR, 6'h0d, 8'h02);
        rd(6'h0d, 8'h1d, "rise enable");
        @(posedge clk);
        src <= 4'ha;
        riseBase = riseCount;
        repeat (10) @(posedge clk);
        chk("masked rise", riseCount, riseBase);
        src <= 4'hb;
        repeat (10) @(posedge clk);
        chk("enabled rise", riseCount, riseBase + 1);
        apb(1'b0, `UOC_APB_STAT, 32'h0);
        chk("event byte", r[23:16], 8'h0b);
        complete_run;
    end
endmodule
